// ### shared/rtc_ctrl_pkg.sv
// Constants, carriers and state layout for the RTC control block.
// Assumes one 40 MHz core clock and a calendar chain outside this block.
package rtc_ctrl_pkg;

  localparam int unsigned CLK_HZ      = 40_000_000;
  localparam int unsigned TIMEOUT_S   = 1;
  localparam int unsigned SAMPLE_MS_0 = 2;
  localparam int unsigned SAMPLE_MS_1 = 16;
  localparam int unsigned SAMPLE_MS_2 = 128;
  localparam int unsigned SAMPLE_MS_3 = 256;
  localparam logic [3:0]  OFFSET_SECONDS = 4'hA;

  localparam logic [6:0] BUS_ADDR = 7'h32;

  localparam logic [7:0] ADDR_ALARM_MIN   = 8'h17;
  localparam logic [7:0] ADDR_ALARM_HOUR  = 8'h18;
  localparam logic [7:0] ADDR_ALARM_DAY   = 8'h19;
  localparam logic [7:0] ADDR_TIMER_LO    = 8'h1A;
  localparam logic [7:0] ADDR_TIMER_HI    = 8'h1B;
  localparam logic [7:0] ADDR_TIMER_ALARM = 8'h1C;
  localparam logic [7:0] ADDR_FLAGS       = 8'h1D;
  localparam logic [7:0] ADDR_IRQ_TIMER   = 8'h1E;
  localparam logic [7:0] ADDR_POWER_MON   = 8'h1F;
  localparam logic [7:0] ADDR_RATE_OFFSET = 8'h30;
  localparam logic [7:0] ADDR_BATT_CHECK  = 8'h31;
  localparam logic [7:0] ADDR_PART_ID     = 8'h3C;
  localparam logic [7:0] ADDR_UNLOCK      = 8'h40;
  localparam logic [7:0] ADDR_FUSE_POWER  = 8'h41;
  localparam logic [7:0] ADDR_FUSE_ADDR   = 8'h42;
  localparam logic [7:0] ADDR_FUSE_DATA   = 8'h44;
  localparam logic [7:0] ADDR_FUSE_RESET  = 8'h45;
  localparam logic [7:0] ADDR_TRIG_FIRST  = 8'h46;
  localparam logic [7:0] ADDR_TRIG_SECOND = 8'h47;
  localparam logic [7:0] ADDR_TRIM_LOAD   = 8'h50;
  localparam logic [7:0] ADDR_TRIM_LO     = 8'h51;
  localparam logic [7:0] ADDR_TRIM_HI     = 8'h52;
  localparam logic [7:0] ADDR_DEBUG_LAST  = 8'h57;

  localparam logic [7:0] RST_ZERO       = 8'h00;
  localparam logic [7:0] RST_FLAGS      = 8'h03;
  localparam logic [7:0] RST_FUSE_POWER = 8'h02;
  localparam logic [7:0] RST_TRIM_LOAD  = 8'h84;
  localparam logic [7:0] RST_TRIM_HI    = 8'h0C;

  localparam logic [7:0] KEY_1 = 8'hA1;
  localparam logic [7:0] KEY_2 = 8'hB2;
  localparam logic [7:0] KEY_3 = 8'hC3;
  localparam logic [7:0] KEY_EXIT = 8'h00;
  localparam logic [7:0] TRIG_ARM = 8'h01;
  localparam logic [7:0] TRIG_FIRE = 8'h00;

  // Field positions
  localparam int FLAG_BATT_LOW = 7;
  localparam int FLAG_UPDATE   = 5;
  localparam int FLAG_TIMER    = 4;
  localparam int FLAG_ALARM    = 3;
  localparam int FLAG_RESET    = 2;
  localparam int FLAG_SUPPLY   = 1;
  localparam int FLAG_FULL     = 0;
  localparam int FUSE_VPP      = 7;
  localparam int FUSE_RDEN     = 3;
  localparam int FUSE_PGMEN    = 2;
  localparam int FUSE_WRITTEN  = 7;
  localparam int FUSE_CLEAR    = 2;
  localparam int FUSE_ATEST    = 0;

  localparam logic [2:0] TSRC_4096 = 3'h0;
  localparam logic [2:0] TSRC_64   = 3'h1;
  localparam logic [2:0] TSRC_1HZ  = 3'h2;
  localparam logic [2:0] TSRC_1MIN = 3'h3;
  localparam logic [2:0] TSRC_1HR  = 3'h4;

  typedef enum logic [3:0] {
    I_IDLE, I_ADDR, I_ADDR_ACK, I_REG, I_REG_ACK,
    I_WR, I_WR_ACK, I_RD, I_RD_ACK
  } i2c_state_e;

  typedef struct packed {
    logic tick_4096;
    logic tick_64;
    logic tick_1hz;
    logic tick_1min;
    logic tick_1hour;
  } tick_s;

  typedef struct packed {
    logic [7:0] minute;
    logic [7:0] hour;
    logic [7:0] weekday;
    logic [7:0] day;
  } now_s;

  typedef struct packed {
    logic on_main;
    logic batt_low;
    logic supply_low;
    logic reset_active;
    logic batt_full;
  } analog_s;

  typedef struct packed {
    logic w32k;
    logic w1024;
    logic w1hz;
  } wave_s;

  typedef struct packed {
    analog_s an1, an2, an3;
    wave_s   wv1, wv2;
    logic    scl1, scl2, scl3, sda1, sda2, sda3;
    i2c_state_e  ist;
    logic [7:0]  shift, tx, ptr;
    logic [3:0]  cnt;
    logic        rw, nack, drive;
    logic [25:0] tmo;
    logic [7:0]  alarm_min, alarm_hour, alarm_day;
    logic [15:0] preset, count;
    logic [7:0]  cfg, flags, ctrl, pwr, offset, batt;
    logic [1:0]  unlock;
    logic [7:0]  fuse_power;
    logic [5:0]  fuse_addr;
    logic [7:0]  fuse_data, fuse_reset, trig1;
    logic [7:0]  trim_load, trim_lo, trim_hi;
    logic [7:0][7:0] fuse_mem;
    logic [3:0]  sec10;
    logic        offset_apply;
    logic [25:0] smp;
    logic        sample;
    logic        fout;
  } st_s;

endpackage

// ### rtl/rtc_ctrl.sv
// RTC control, status, fuse sequencer and two-wire target interface.
// Assumes ticks and time come from calendar logic on core_clk; pins,
// analog levels and divider waves are asynchronous and synchronised here.
//
// Functional notes
// - Update event always on; select second or minute
// - Day-mode bit picks weekday or day alarm
// - Timer runs when enabled; source from select
// - Event flags set by hardware, cleared writing 0
// - Battery-full flag follows battery level live
// - Stop bit freezes time chain when set
// - Update, timer and alarm events drive interrupt pin only if enabled
// - Pause bit holds timer count, resumes after
// - Domain bits restrict timer to one supply
// - Sample period field picks 2/16/128/256 ms
// - Bus-gate bit disables bus during reset output
// - Offset correction applied once every ten seconds
// - Seven-bit signed offset, 3.05 ppm steps
// - Battery-low check needs main supply, gate, enable or charge mode
// - Three-key unlock opens debug space; 0x00 exits
// - Trigger 0x01 then 0x00 fires fuse operation
// - Fuse address: bit index high, byte low
// - Shadow-load bit copies fuses into trim registers
// - Responds only at seven-bit address 0110010
// - Transaction over one second resets bus interface
// - Register pointer increments per byte, wraps
// - Clock-out select picks 32768/1024/1 Hz or off
// - Alarm match sets flag, interrupt if enabled
`timescale 1ns/10ps
module rtc_ctrl
  import rtc_ctrl_pkg::*;
#(
  parameter int unsigned TIMEOUT_CYCLES  = CLK_HZ * TIMEOUT_S,
  parameter int unsigned SAMPLE_CYCLES_0 = CLK_HZ / 1000 * SAMPLE_MS_0,
  parameter int unsigned SAMPLE_CYCLES_1 = CLK_HZ / 1000 * SAMPLE_MS_1,
  parameter int unsigned SAMPLE_CYCLES_2 = CLK_HZ / 1000 * SAMPLE_MS_2,
  parameter int unsigned SAMPLE_CYCLES_3 = CLK_HZ / 1000 * SAMPLE_MS_3,
  // Arbitrary value, stands in for the part code
  parameter logic [7:0]  PART_CODE       = 8'h5A
) (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe,
  output logic             irq_n_o,
  output logic             irq_n_oe,
  input  wire tick_s       ticks,
  input  wire now_s        now,
  input  wire analog_s     analog,
  input  wire wave_s       waves,
  output logic             fout,
  output logic             time_stop,
  output logic             offset_enable,
  output logic [6:0]       offset_value,
  output logic             offset_apply,
  output logic             supply_sample,
  output logic             battery_check_active,
  output logic             charge_mode_enable,
  output logic             reset_threshold_select,
  output logic [1:0]       full_threshold_select,
  output logic [7:0]       fuse_power,
  output logic             analog_test,
  output logic [10:0]      osc_trim
);

  st_s s_reg;
  st_s s_next;

  function automatic logic [25:0] sample_len(input logic [1:0] code);
    case (code)
      2'h0:    sample_len = 26'(SAMPLE_CYCLES_0 - 1);
      2'h1:    sample_len = 26'(SAMPLE_CYCLES_1 - 1);
      2'h2:    sample_len = 26'(SAMPLE_CYCLES_2 - 1);
      default: sample_len = 26'(SAMPLE_CYCLES_3 - 1);
    endcase
  endfunction

  function automatic logic in_debug(input logic [7:0] a);
    in_debug = (a > ADDR_UNLOCK) && (a <= ADDR_DEBUG_LAST);
  endfunction

  function automatic logic [7:0] reg_read(input st_s st,
                                          input logic [7:0] a);
    logic [7:0] d;
    d = 8'h00;
    case (a)
      ADDR_ALARM_MIN:   d = st.alarm_min;
      ADDR_ALARM_HOUR:  d = st.alarm_hour;
      ADDR_ALARM_DAY:   d = st.alarm_day;
      ADDR_TIMER_LO:    d = st.count[7:0];
      ADDR_TIMER_HI:    d = st.count[15:8];
      ADDR_TIMER_ALARM: d = st.cfg;
      ADDR_FLAGS:       d = st.flags;
      ADDR_IRQ_TIMER:   d = st.ctrl;
      ADDR_POWER_MON:   d = st.pwr;
      ADDR_RATE_OFFSET: d = st.offset;
      ADDR_BATT_CHECK:  d = st.batt;
      ADDR_PART_ID:     d = PART_CODE;
      ADDR_UNLOCK:      d = {7'h00, &st.unlock};
      ADDR_FUSE_POWER:  d = st.fuse_power;
      ADDR_FUSE_ADDR:   d = {2'h0, st.fuse_addr};
      ADDR_FUSE_DATA:   d = st.fuse_data;
      ADDR_FUSE_RESET:  d = st.fuse_reset;
      ADDR_TRIG_FIRST:  d = st.trig1;
      ADDR_TRIM_LOAD:   d = st.trim_load;
      ADDR_TRIM_LO:     d = st.trim_lo;
      ADDR_TRIM_HI:     d = st.trim_hi;
      default:          d = 8'h00;
    endcase
    if (in_debug(a) && !(&st.unlock)) begin
      d = 8'h00;
    end
    reg_read = d;
  endfunction

  logic       scl, sda, scl_rise, scl_fall, start_c, stop_c;
  logic       wr_en;
  logic [7:0] wr_data;
  logic       tick_sel, run, dom_ok, alarm_hit, upd_tick;
  logic       fire;
  logic [2:0] fbit, fbyte;

  always_comb begin
    s_next = s_reg;
    scl = s_reg.scl2;
    sda = s_reg.sda2;
    scl_rise = scl && !s_reg.scl3;
    scl_fall = !scl && s_reg.scl3;
    start_c = scl && s_reg.scl3 && !sda && s_reg.sda3;
    stop_c = scl && s_reg.scl3 && sda && !s_reg.sda3;
    wr_en = 1'b0;
    wr_data = s_reg.shift;
    tick_sel = 1'b0;
    fire = 1'b0;
    fbit = s_reg.fuse_addr[5:3];
    fbyte = s_reg.fuse_addr[2:0];

    s_next.an1 = analog;
    s_next.an2 = s_reg.an1;
    s_next.an3 = s_reg.an2;
    s_next.wv1 = waves;
    s_next.wv2 = s_reg.wv1;
    s_next.scl1 = scl_i;
    s_next.scl2 = s_reg.scl1;
    s_next.scl3 = s_reg.scl2;
    s_next.sda1 = sda_i;
    s_next.sda2 = s_reg.sda1;
    s_next.sda3 = s_reg.sda2;

    // Two-wire target; timeout and reset gating take priority
    if (s_reg.ist != I_IDLE) begin
      s_next.tmo = s_reg.tmo + 26'd1;
    end else begin
      s_next.tmo = 26'd0;
    end
    if (stop_c || (s_reg.pwr[4] && s_reg.an2.reset_active) ||
        (s_reg.tmo == 26'(TIMEOUT_CYCLES - 1))) begin
      s_next.ist = I_IDLE;
      s_next.drive = 1'b0;
    end else if (start_c) begin
      s_next.ist = I_ADDR;
      s_next.cnt = 4'h0;
      s_next.drive = 1'b0;
      s_next.tmo = 26'd0;
    end else begin
      if (scl_rise) begin
        s_next.shift = {s_reg.shift[6:0], sda};
        s_next.cnt = s_reg.cnt + 4'h1;
      end
      case (s_reg.ist)
        I_ADDR: if (scl_fall && s_reg.cnt == 4'h8) begin
          if (s_reg.shift[7:1] == BUS_ADDR) begin
            s_next.rw = s_reg.shift[0];
            s_next.drive = 1'b1;
            s_next.ist = I_ADDR_ACK;
          end else begin
            s_next.ist = I_IDLE;
          end
        end
        I_ADDR_ACK: if (scl_fall) begin
          s_next.cnt = 4'h0;
          if (s_reg.rw) begin
            s_next.tx = reg_read(s_reg, s_reg.ptr);
            s_next.drive = !s_next.tx[7];
            s_next.ist = I_RD;
          end else begin
            s_next.drive = 1'b0;
            s_next.ist = I_REG;
          end
        end
        I_REG: if (scl_fall && s_reg.cnt == 4'h8) begin
          s_next.ptr = s_reg.shift;
          s_next.drive = 1'b1;
          s_next.ist = I_REG_ACK;
        end
        I_WR: if (scl_fall && s_reg.cnt == 4'h8) begin
          wr_en = 1'b1;
          s_next.ptr = s_reg.ptr + 8'h01;
          s_next.drive = 1'b1;
          s_next.ist = I_WR_ACK;
        end
        I_REG_ACK, I_WR_ACK: if (scl_fall) begin
          s_next.drive = 1'b0;
          s_next.cnt = 4'h0;
          s_next.ist = I_WR;
        end
        I_RD: if (scl_fall) begin
          if (s_reg.cnt == 4'h8) begin
            s_next.drive = 1'b0;
            s_next.ptr = s_reg.ptr + 8'h01;
            s_next.ist = I_RD_ACK;
          end else begin
            s_next.tx = {s_reg.tx[6:0], 1'b0};
            s_next.drive = !s_reg.tx[6];
          end
        end
        I_RD_ACK: begin
          if (scl_rise) begin
            s_next.nack = sda;
          end
          if (scl_fall) begin
            s_next.cnt = 4'h0;
            if (s_reg.nack) begin
              s_next.ist = I_IDLE;
            end else begin
              s_next.tx = reg_read(s_reg, s_reg.ptr);
              s_next.drive = !s_next.tx[7];
              s_next.ist = I_RD;
            end
          end
        end
        I_IDLE: s_next.drive = 1'b0;
        default: s_next.ist = I_IDLE;
      endcase
    end

    // Register writes
    if (wr_en && !(in_debug(s_reg.ptr) && !(&s_reg.unlock))) begin
      case (s_reg.ptr)
        ADDR_ALARM_MIN:   s_next.alarm_min = wr_data;
        ADDR_ALARM_HOUR:  s_next.alarm_hour = wr_data;
        ADDR_ALARM_DAY:   s_next.alarm_day = wr_data;
        ADDR_TIMER_LO: begin
          s_next.preset[7:0] = wr_data;
          s_next.count[7:0] = wr_data;
        end
        ADDR_TIMER_HI: begin
          s_next.preset[15:8] = wr_data;
          s_next.count[15:8] = wr_data;
        end
        ADDR_TIMER_ALARM: s_next.cfg = wr_data;
        ADDR_FLAGS:       s_next.flags = s_reg.flags & wr_data;
        ADDR_IRQ_TIMER:   s_next.ctrl = wr_data;
        ADDR_POWER_MON:   s_next.pwr = wr_data;
        ADDR_RATE_OFFSET: s_next.offset = wr_data;
        ADDR_BATT_CHECK:  s_next.batt = {7'h00, wr_data[0]};
        ADDR_UNLOCK: begin
          if (wr_data == KEY_EXIT) begin
            s_next.unlock = 2'h0;
          end else if (wr_data == KEY_1 && s_reg.unlock == 2'h0) begin
            s_next.unlock = 2'h1;
          end else if (wr_data == KEY_2 && s_reg.unlock == 2'h1) begin
            s_next.unlock = 2'h2;
          end else if (wr_data == KEY_3 && s_reg.unlock == 2'h2) begin
            s_next.unlock = 2'h3;
          end else if (s_reg.unlock != 2'h3) begin
            s_next.unlock = 2'h0;
          end
        end
        ADDR_FUSE_POWER:  s_next.fuse_power = wr_data;
        ADDR_FUSE_ADDR:   s_next.fuse_addr = wr_data[5:0];
        ADDR_FUSE_RESET: begin
          s_next.fuse_reset[FUSE_CLEAR] = wr_data[FUSE_CLEAR];
          s_next.fuse_reset[FUSE_ATEST] = wr_data[FUSE_ATEST];
          if (!wr_data[FUSE_WRITTEN]) begin
            s_next.fuse_reset[FUSE_WRITTEN] = 1'b0;
          end
        end
        ADDR_TRIG_FIRST:  s_next.trig1 = {7'h00, wr_data[0]};
        ADDR_TRIG_SECOND: begin
          if (wr_data == TRIG_FIRE && s_reg.trig1 == TRIG_ARM) begin
            fire = 1'b1;
            s_next.trig1 = 8'h00;
          end
        end
        ADDR_TRIM_LOAD:   s_next.trim_load = wr_data;
        ADDR_TRIM_LO:     s_next.trim_lo = wr_data;
        ADDR_TRIM_HI:     s_next.trim_hi = wr_data;
        default:          s_next.ptr = s_next.ptr;
      endcase
    end

    // Fuse operation; programming needs both power and program enable
    if (fire) begin
      if (s_reg.fuse_power[FUSE_PGMEN] && s_reg.fuse_power[FUSE_VPP]) begin
        s_next.fuse_mem[fbyte][fbit] = 1'b1;
        s_next.fuse_reset[FUSE_WRITTEN] = 1'b1;
      end else if (s_reg.fuse_power[FUSE_RDEN]) begin
        s_next.fuse_data = s_reg.fuse_mem[fbyte];
      end
    end
    if (s_reg.fuse_reset[FUSE_CLEAR]) begin
      s_next.fuse_data = 8'h00;
    end
    // Shadow load overrides bus writes while held
    if (s_reg.trim_load[0]) begin
      s_next.trim_load = {s_reg.fuse_mem[0][7:1], 1'b1};
      s_next.trim_lo = s_reg.fuse_mem[1];
      s_next.trim_hi = s_reg.fuse_mem[2];
    end

    // Countdown timer
    case (s_reg.cfg[2:0])
      TSRC_4096: tick_sel = ticks.tick_4096;
      TSRC_64:   tick_sel = ticks.tick_64;
      TSRC_1HZ:  tick_sel = ticks.tick_1hz;
      TSRC_1MIN: tick_sel = ticks.tick_1min;
      TSRC_1HR:  tick_sel = ticks.tick_1hour;
      default:   tick_sel = 1'b0;
    endcase
    dom_ok = !s_reg.ctrl[0] ||
             (s_reg.ctrl[1] == s_reg.an2.on_main);
    run = s_reg.cfg[4] && !s_reg.ctrl[2] && dom_ok;
    if (tick_sel && run) begin
      if (s_reg.count == 16'h0001 || s_reg.count == 16'h0000) begin
        s_next.count = s_reg.preset;
      end else begin
        s_next.count = s_reg.count - 16'h0001;
      end
    end

    // Alarm compare on each new minute
    alarm_hit = !(s_reg.alarm_min[7] && s_reg.alarm_hour[7] &&
                  s_reg.alarm_day[7]);
    if (!s_reg.alarm_min[7] && s_reg.alarm_min[6:0] != now.minute[6:0]) begin
      alarm_hit = 1'b0;
    end
    if (!s_reg.alarm_hour[7] &&
        s_reg.alarm_hour[5:0] != now.hour[5:0]) begin
      alarm_hit = 1'b0;
    end
    if (!s_reg.alarm_day[7]) begin
      if (s_reg.cfg[3]) begin
        if (s_reg.alarm_day[5:0] != now.day[5:0]) begin
          alarm_hit = 1'b0;
        end
      end else if ((s_reg.alarm_day[6:0] & now.weekday[6:0]) == 7'h00) begin
        alarm_hit = 1'b0;
      end
    end

    // Sticky event flags: events set after the clear, so a set wins; battery-full flag stays live
    upd_tick = s_reg.cfg[5] ? ticks.tick_1min : ticks.tick_1hz;
    if (upd_tick) begin
      s_next.flags[FLAG_UPDATE] = 1'b1;
    end
    if (tick_sel && run && s_reg.count == 16'h0001) begin
      s_next.flags[FLAG_TIMER] = 1'b1;
    end
    if (ticks.tick_1min && alarm_hit) begin
      s_next.flags[FLAG_ALARM] = 1'b1;
    end
    if (s_reg.an2.reset_active && !s_reg.an3.reset_active) begin
      s_next.flags[FLAG_RESET] = 1'b1;
    end
    if (s_reg.an2.supply_low && !s_reg.an3.supply_low) begin
      s_next.flags[FLAG_SUPPLY] = 1'b1;
    end
    if (s_reg.an2.batt_low && !s_reg.an3.batt_low && battery_check_active) begin
      s_next.flags[FLAG_BATT_LOW] = 1'b1;
    end
    s_next.flags[6] = 1'b0;
    s_next.flags[FLAG_FULL] = s_reg.an2.batt_full;

    // Offset correction once per ten seconds
    s_next.offset_apply = 1'b0;
    if (!s_reg.offset[7]) begin
      s_next.sec10 = 4'h0;
    end else if (ticks.tick_1hz) begin
      if (s_reg.sec10 == OFFSET_SECONDS - 4'h1) begin
        s_next.sec10 = 4'h0;
        s_next.offset_apply = 1'b1;
      end else begin
        s_next.sec10 = s_reg.sec10 + 4'h1;
      end
    end

    // Supply monitor strobe
    s_next.sample = 1'b0;
    if (s_reg.smp >= sample_len(s_reg.pwr[7:6])) begin
      s_next.smp = 26'd0;
      s_next.sample = 1'b1;
    end else begin
      s_next.smp = s_reg.smp + 26'd1;
    end

    case (s_reg.cfg[7:6])
      2'h0:    s_next.fout = s_reg.wv2.w32k;
      2'h1:    s_next.fout = s_reg.wv2.w1024;
      2'h2:    s_next.fout = s_reg.wv2.w1hz;
      default: s_next.fout = 1'b0;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      s_reg <= '0;
      s_reg.ist <= I_IDLE;
      s_reg.flags <= RST_FLAGS;
      s_reg.fuse_power <= RST_FUSE_POWER;
      s_reg.trim_load <= RST_TRIM_LOAD;
      s_reg.trim_hi <= RST_TRIM_HI;
      s_reg.scl1 <= 1'b1;
      s_reg.scl2 <= 1'b1;
      s_reg.scl3 <= 1'b1;
      s_reg.sda1 <= 1'b1;
      s_reg.sda2 <= 1'b1;
      s_reg.sda3 <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  // Battery check also needs the bus gate; never in backup
  assign battery_check_active = s_reg.an2.on_main && s_reg.pwr[4] &&
                                (s_reg.batt[0] || s_reg.pwr[5]);
  assign sda_o = 1'b0;
  assign sda_oe = s_reg.drive;
  assign irq_n_o = 1'b0;
  assign irq_n_oe = (s_reg.flags[FLAG_UPDATE] && s_reg.ctrl[5]) ||
                    (s_reg.flags[FLAG_TIMER] && s_reg.ctrl[4]) ||
                    (s_reg.flags[FLAG_ALARM] && s_reg.ctrl[3]);
  assign fout = s_reg.fout;
  assign time_stop = s_reg.ctrl[6];
  assign offset_enable = s_reg.offset[7];
  assign offset_value = s_reg.offset[6:0];
  assign offset_apply = s_reg.offset_apply;
  assign supply_sample = s_reg.sample;
  assign charge_mode_enable = s_reg.pwr[5];
  assign reset_threshold_select = s_reg.pwr[2];
  assign full_threshold_select = s_reg.pwr[1:0];
  assign fuse_power = s_reg.fuse_power;
  assign analog_test = s_reg.fuse_reset[FUSE_ATEST];
  assign osc_trim = {s_reg.trim_hi[7:5], s_reg.trim_lo};

endmodule

// ### dv/rtc_ctrl_assertions.sv
// Port checker for the RTC control block.
// Assumes one core clock and synchronous active-high reset.
`timescale 1ns/10ps
module rtc_ctrl_assertions
  import rtc_ctrl_pkg::*;
(
  input wire logic       core_clk,
  input wire logic       rst,
  input wire logic       scl_i,
  input wire logic       sda_o,
  input wire logic       sda_oe,
  input wire logic       irq_n_o,
  input wire analog_s    analog,
  input wire logic       offset_apply,
  input wire logic       offset_enable,
  input wire logic       supply_sample,
  input wire logic       battery_check_active,
  input wire logic [7:0] fuse_power
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  sequence s_quiet;
    !supply_sample [*8];
  endsequence
  AST_OPEN_DRAIN: assert property (!sda_o && !irq_n_o)
    else $error("open-drain pin driven high");
  AST_ACK_ON_LOW: assert property ($rose(sda_oe) |-> !scl_i)
    else $error("data line pulled while clock high");
  AST_SDA_HELD: assert property (
    scl_i && $past(scl_i) |-> $stable(sda_oe))
    else $error("data line moved while clock high");
  AST_APPLY_PULSE: assert property (offset_apply |=> !offset_apply)
    else $error("offset pulse longer than one cycle");
  AST_APPLY_EN: assert property (offset_apply |-> offset_enable)
    else $error("offset pulse while disabled");
  AST_SAMPLE_GAP: assert property (supply_sample |=> s_quiet)
    else $error("supply samples too close");
  AST_BATT_MAIN: assert property (
    battery_check_active |-> $past(analog.on_main, 2))
    else $error("battery check off main supply");
  AST_REG_ON_FALL: assert property ($changed(fuse_power) |-> !scl_i)
    else $error("register changed while clock high");
endmodule
bind rtc_ctrl rtc_ctrl_assertions rtc_ctrl_assertions_inst (
  .core_clk(core_clk), .rst(rst), .scl_i(scl_i), .sda_o(sda_o),
  .sda_oe(sda_oe), .irq_n_o(irq_n_o), .analog(analog),
  .offset_apply(offset_apply), .offset_enable(offset_enable),
  .supply_sample(supply_sample),
  .battery_check_active(battery_check_active), .fuse_power(fuse_power));

// ### dv/i2c_host_model.sv
// Two-wire bus host that reaches the RTC registers.
// Assumes open-drain data with pull-up; paced by core_clk.
`timescale 1ns/10ps
module i2c_host_model (
  input  wire logic core_clk,
  input  wire logic sda_oe,
  output logic      scl,
  output logic      sda
);
  logic scl_r = 1'b1;
  logic sd_r  = 1'b1;
  assign sda = sd_r & ~sda_oe;
  assign scl = scl_r;
  task automatic q();
    repeat (8) @(negedge core_clk);
  endtask
  task automatic bt(input logic b, output logic o);
    sd_r = b;
    q();
    scl_r = 1'b1;
    q();
    o = sda;
    q();
    scl_r = 1'b0;
    q();
  endtask
  task automatic wb(input logic [7:0] d, output logic k);
    logic o;
    for (int i = 7; i >= 0; i--) bt(d[i], o);
    bt(1'b1, o);
    k = ~o;
  endtask
  // Short frames keep every transaction far inside the timeout
  task automatic xfer(input logic [7:0] dev, input logic [7:0] a,
      input logic rd, input int n, input logic [15:0] d,
      output logic [15:0] v, output logic ok);
    logic k;
    logic o;
    v = '0;
    sd_r = 1'b1;
    q();
    scl_r = 1'b1;
    q();
    sd_r = 1'b0;
    q();
    scl_r = 1'b0;
    wb(dev, ok);
    wb(a, k);
    ok &= k;
    if (rd) begin
      sd_r = 1'b1;
      q();
      scl_r = 1'b1;
      q();
      sd_r = 1'b0;
      q();
      scl_r = 1'b0;
      wb(dev | 8'h01, k);
      ok &= k;
      for (int i = 0; i < n; i++) begin
        for (int j = 7; j >= 0; j--) bt(1'b1, v[8*i+j]);
        bt(i == n - 1, o);
      end
    end else begin
      for (int i = 0; i < n; i++) begin
        wb(d[8*i +: 8], k);
        ok &= k;
      end
    end
    sd_r = 1'b0;
    q();
    scl_r = 1'b1;
    q();
    sd_r = 1'b1;
    q();
  endtask
endmodule

// ### dv/testbench.sv
// Self-checking bench for the RTC control block.
// Assumes the host model owns the bus pins; the rest is driven here.
`timescale 1ns/10ps
module testbench
  import rtc_ctrl_pkg::*;
;
  // Arbitrary value for the part code
  localparam logic [7:0] PCODE = 8'h3E;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  tick_s ticks = '0;
  analog_s analog = '0;
  wave_s waves = '0;
  logic scl, sda, sda_oe, irq_n_oe, apply, bchk, fo;
  logic [6:0] ofs;
  logic [7:0] fpow;
  int err_total = 0;
  int samples_checked = 0;
  int cyc = 0;
  int apply_cnt = 0;
  always #12.5 core_clk = ~core_clk;
  rtc_ctrl #(.TIMEOUT_CYCLES(4000), .SAMPLE_CYCLES_0(20),
    .SAMPLE_CYCLES_1(40), .SAMPLE_CYCLES_2(60), .SAMPLE_CYCLES_3(80),
    .PART_CODE(PCODE)) rtc_ctrl_inst (
    .core_clk(core_clk), .rst(rst), .scl_i(scl), .sda_i(sda),
    .sda_o(), .sda_oe(sda_oe), .irq_n_o(), .irq_n_oe(irq_n_oe),
    .ticks(ticks), .now('0), .analog(analog), .waves(waves), .fout(fo),
    .time_stop(), .offset_enable(), .offset_value(ofs),
    .offset_apply(apply), .supply_sample(), .battery_check_active(bchk),
    .charge_mode_enable(), .reset_threshold_select(),
    .full_threshold_select(), .fuse_power(fpow), .analog_test(),
    .osc_trim());
  i2c_host_model i2c_host_model_inst (.core_clk(core_clk),
    .sda_oe(sda_oe), .scl(scl), .sda(sda));
  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cyc++;
    if (apply === 1'b1) apply_cnt++;
    if (cyc == 80000) begin
      err_total++;
      results();
    end
  end
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    samples_checked++;
    if (g !== e) begin
      err_total++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic rw(input logic [7:0] a, input logic rd, input int n,
      input logic [15:0] d, output logic [15:0] v);
    logic ok;
    i2c_host_model_inst.xfer(8'h64, a, rd, n, d, v, ok);
    chk({15'h0, ok}, 16'h1);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [15:0] v;
    rw(a, 1'b0, 1, {8'h00, d}, v);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    logic [15:0] v;
    rw(a, 1'b1, 1, 16'h0, v);
    chk(v, {8'h00, e});
  endtask
  task automatic t_reset_id();
    rdc(ADDR_RATE_OFFSET, RST_ZERO);
    rdc(ADDR_FLAGS, 8'h02);
    wr(ADDR_PART_ID, 8'h00);
    rdc(ADDR_PART_ID, PCODE);
  endtask
  task automatic t_flags();
    wr(ADDR_FLAGS, 8'h00);
    rdc(ADDR_FLAGS, 8'h00);
    analog.batt_full = 1'b1;
    rdc(ADDR_FLAGS, 8'h01);
    analog.batt_full = 1'b0;
    rdc(ADDR_FLAGS, 8'h00);
  endtask
  task automatic t_burst_batt();
    logic [15:0] v;
    analog.on_main = 1'b1;
    rw(ADDR_RATE_OFFSET, 1'b0, 2, 16'h0107, v);
    rw(ADDR_RATE_OFFSET, 1'b1, 2, 16'h0, v);
    chk(v, 16'h0107);
    chk({9'h0, ofs}, 16'h0007);
    wr(ADDR_POWER_MON, 8'h10);
    chk({15'h0, bchk}, 16'h1);
    wr(ADDR_POWER_MON, 8'h00);
    chk({15'h0, bchk}, 16'h0);
    waves.w32k = 1'b1;
    repeat (4) @(negedge core_clk);
    chk({15'h0, fo}, 16'h1);
    wr(ADDR_TIMER_ALARM, 8'hC0);
    chk({15'h0, fo}, 16'h0);
  endtask
  task automatic t_update_offset();
    wr(ADDR_RATE_OFFSET, 8'h85);
    apply_cnt = 0;
    repeat (10) begin
      @(negedge core_clk) ticks.tick_1hz = 1'b1;
      @(negedge core_clk) ticks.tick_1hz = 1'b0;
      repeat (4) @(negedge core_clk);
    end
    chk(apply_cnt[15:0], 16'h1);
    rdc(ADDR_FLAGS, 8'h20);
    chk({15'h0, irq_n_oe}, 16'h0);
    wr(ADDR_IRQ_TIMER, 8'h20);
    chk({15'h0, irq_n_oe}, 16'h1);
    wr(ADDR_FLAGS, 8'h00);
    chk({15'h0, irq_n_oe}, 16'h0);
  endtask
  task automatic t_debug_lock();
    logic [15:0] v;
    logic ok;
    wr(ADDR_FUSE_POWER, 8'hFF);
    rdc(ADDR_FUSE_POWER, 8'h00);
    chk({8'h0, fpow}, {8'h0, RST_FUSE_POWER});
    wr(ADDR_UNLOCK, KEY_1);
    wr(ADDR_UNLOCK, KEY_2);
    wr(ADDR_UNLOCK, KEY_3);
    wr(ADDR_FUSE_POWER, 8'h09);
    rdc(ADDR_FUSE_POWER, 8'h09);
    chk({8'h0, fpow}, 16'h0009);
    wr(ADDR_FUSE_ADDR, 8'h19);
    rdc(ADDR_FUSE_ADDR, 8'h19);
    wr(ADDR_FUSE_POWER, 8'h85);
    rw(ADDR_TRIG_FIRST, 1'b0, 2, 16'h0001, v);
    rw(ADDR_FUSE_POWER, 1'b0, 2, 16'h0109, v);
    rw(ADDR_TRIG_FIRST, 1'b0, 2, 16'h0001, v);
    rdc(ADDR_FUSE_DATA, 8'h08);
    wr(ADDR_UNLOCK, KEY_EXIT);
    rdc(ADDR_FUSE_POWER, 8'h00);
    i2c_host_model_inst.xfer(8'h66, ADDR_FLAGS, 1'b0, 1, 16'h0, v, ok);
    chk({15'h0, ok}, 16'h0);
  endtask
  initial begin
    repeat (5) @(negedge core_clk);
    rst = 1'b0;
    repeat (5) @(negedge core_clk);
    t_reset_id();
    t_flags();
    t_burst_batt();
    t_update_offset();
    t_debug_lock();
    results();
  end
endmodule
